// >>> logic/ufc_config.sv
// Frame, baud, auto-baud window, debug and infrared configuration of a serial port
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns
module ufc_config
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // System state
   input wire logic cpu_debug_halted,
   input wire logic constrained_autobaud_mode,
   // Auto-baud measurement
   input wire logic sync_count_valid,
   input wire logic [7:0] sync_count,
   // Infrared paths
   input wire logic infrared_event_pin,
   input wire logic tx_serial_bit,
   output logic ir_tx_out,
   output logic ir_event_level,
   // Baud timing
   output logic baud_tick,
   output logic bit_tick,
   // Decoded configuration
   output logic multiproc_addressing_enable,
   output logic [1:0] comm_mode_select,
   output logic parity_enable,
   output logic parity_odd,
   output logic stop_bit_count,
   output logic [3:0] char_bits,
   output logic nine_bit_high_first,
   output logic shift_order,
   output logic sample_phase,
   output logic autobaud_checked,
   output logic autobaud_in_window,
   output logic port_halted
);

   //**********************************************************************
   // State
   //**********************************************************************
   typedef struct packed {
      logic mp_enable;
      logic [1:0] mode;
      logic [1:0] parity;
      logic stop2;
      logic [2:0] size_code;
      logic order;
      logic phase;
      logic [15:0] baud;
      logic [1:0] window;
      logic dbg_run;
      logic ev_disable;
      logic [7:0] pulse_len;
      logic [7:0] rdata;
      logic [15:0] presc;
      logic [3:0] sample;
      logic btick;
      logic bitt;
      logic ev_s1;
      logic ev_s2;
      logic ev_s3;
      logic ev_level;
      logic [7:0] ir_left;
      logic ir_in_samples;
      logic ir_out;
      logic ab_checked;
      logic ab_ok;
   } ufc_state_type;

   ufc_state_type state_ff;
   ufc_state_type nxt_state;
   logic halted;
   logic [7:0] tol;
   logic [7:0] frame_read;
   logic bit_start;

   //**********************************************************************
   // Combinational helpers
   //**********************************************************************
   // Halt only when the CPU sits in debug and run is not allowed
   assign halted = cpu_debug_halted & ~state_ff.dbg_run;

   // Tolerance of the auto-baud window
   always_comb
   begin
      unique case (state_ff.window)
         2'h0: tol = ufc_pkg::TOL_W0;
         2'h1: tol = ufc_pkg::TOL_W1;
         2'h2: tol = ufc_pkg::TOL_W2;
         2'h3: tol = ufc_pkg::TOL_W3;
      endcase
   end

   // Frame control read view depends on the stored mode
   always_comb
   begin
      if (state_ff.mode == ufc_pkg::MODE_SPI)
      begin
         frame_read = 8'h00;
         frame_read[ufc_pkg::FC_MODE_LSB +: 2] = state_ff.mode;
         frame_read[ufc_pkg::FC_ORDER_BIT] = state_ff.order;
         frame_read[ufc_pkg::FC_PHASE_BIT] = state_ff.phase;
      end
      else
      begin
         frame_read = {state_ff.mode, state_ff.parity, state_ff.stop2, state_ff.size_code};
      end
   end

   // A bit period begins on the sample tick that wraps the sample count
   assign bit_start = state_ff.btick && (state_ff.sample == 4'h0);

   //**********************************************************************
   // Next state
   //**********************************************************************
   always_comb
   begin
      nxt_state = state_ff;
      nxt_state.btick = 1'b0;
      nxt_state.bitt = 1'b0;
      nxt_state.ab_checked = 1'b0;

      // Register writes
      if (reg_write)
      begin
         unique case (reg_addr)
            ufc_pkg::OFF_CTRL_B: nxt_state.mp_enable = reg_wdata[0];
            ufc_pkg::OFF_FRAME:
            begin
               nxt_state.mode = reg_wdata[ufc_pkg::FC_MODE_LSB +: 2];
               if (reg_wdata[ufc_pkg::FC_MODE_LSB +: 2] == ufc_pkg::MODE_SPI)
               begin
                  // SPI layout: only mode, order and phase are stored
                  nxt_state.order = reg_wdata[ufc_pkg::FC_ORDER_BIT];
                  nxt_state.phase = reg_wdata[ufc_pkg::FC_PHASE_BIT];
               end
               else
               begin
                  // Normal layout comes back with whatever is written
                  nxt_state.parity = reg_wdata[ufc_pkg::FC_PAR_LSB +: 2];
                  nxt_state.stop2 = reg_wdata[ufc_pkg::FC_STOP_BIT];
                  nxt_state.size_code = reg_wdata[2:0];
                  nxt_state.order = 1'b0;
                  nxt_state.phase = 1'b0;
               end
            end
            ufc_pkg::OFF_BAUD_LO: nxt_state.baud[7:0] = reg_wdata;
            ufc_pkg::OFF_BAUD_HI: nxt_state.baud[15:8] = reg_wdata;
            ufc_pkg::OFF_WINDOW: nxt_state.window = reg_wdata[ufc_pkg::WIN_LSB +: 2];
            ufc_pkg::OFF_DEBUG: nxt_state.dbg_run = reg_wdata[0];
            ufc_pkg::OFF_EVENT: nxt_state.ev_disable = reg_wdata[0];
            ufc_pkg::OFF_PULSE: nxt_state.pulse_len = reg_wdata;
            default: ;
         endcase
      end

      // Register reads, answered in the next cycle; unmapped reads give zero
      nxt_state.rdata = 8'h00;
      if (reg_read)
      begin
         unique case (reg_addr)
            ufc_pkg::OFF_CTRL_B: nxt_state.rdata = {7'h00, state_ff.mp_enable};
            ufc_pkg::OFF_FRAME: nxt_state.rdata = frame_read;
            ufc_pkg::OFF_BAUD_LO: nxt_state.rdata = state_ff.baud[7:0];
            ufc_pkg::OFF_BAUD_HI: nxt_state.rdata = state_ff.baud[15:8];
            ufc_pkg::OFF_WINDOW: nxt_state.rdata = {state_ff.window, 6'h00};
            ufc_pkg::OFF_DEBUG: nxt_state.rdata = {7'h00, state_ff.dbg_run};
            ufc_pkg::OFF_EVENT: nxt_state.rdata = {7'h00, state_ff.ev_disable};
            ufc_pkg::OFF_PULSE: nxt_state.rdata = state_ff.pulse_len;
            default: nxt_state.rdata = 8'h00;
         endcase
      end

      // Baud prescaler; a divisor write wins over counting and may break a frame
      if (reg_write && (reg_addr == ufc_pkg::OFF_BAUD_LO))
      begin
         nxt_state.presc = {state_ff.baud[15:8], reg_wdata};
      end
      else if (reg_write && (reg_addr == ufc_pkg::OFF_BAUD_HI))
      begin
         nxt_state.presc = {reg_wdata, state_ff.baud[7:0]};
      end
      else if (!halted)
      begin
         if (state_ff.presc == 16'h0000)
         begin
            nxt_state.presc = state_ff.baud;
            nxt_state.btick = 1'b1;
            // Sixteen sample ticks make one bit
            nxt_state.sample = state_ff.sample + 4'h1;
            nxt_state.bitt = (state_ff.sample == ufc_pkg::SAMPLES_LAST);
         end
         else
         begin
            nxt_state.presc = state_ff.presc - 16'h0001;
         end
      end

      // Event pin synchroniser; the level moves only when stages two and three agree
      nxt_state.ev_s1 = infrared_event_pin;
      nxt_state.ev_s2 = state_ff.ev_s1;
      nxt_state.ev_s3 = state_ff.ev_s2;
      if (!state_ff.ev_disable && !halted && (state_ff.ev_s2 == state_ff.ev_s3))
      begin
         nxt_state.ev_level = state_ff.ev_s3;
      end

      // Auto-baud window check; without the constrained mode any count passes
      if (sync_count_valid && !halted)
      begin
         nxt_state.ab_checked = 1'b1;
         if (constrained_autobaud_mode)
         begin
            nxt_state.ab_ok = (sync_count >= (ufc_pkg::PAIR_NOMINAL - tol)) &&
                              (sync_count <= (ufc_pkg::PAIR_NOMINAL + tol));
         end
         else
         begin
            nxt_state.ab_ok = 1'b1;
         end
      end

      // Infrared transmit encoder: a zero bit sends a pulse, a one sends none
      if ((state_ff.mode != ufc_pkg::MODE_IR) || (state_ff.pulse_len == ufc_pkg::PULSE_PASS))
      begin
         nxt_state.ir_out = tx_serial_bit;
         nxt_state.ir_left = 8'h00;
         nxt_state.ir_in_samples = 1'b0;
      end
      else if (bit_start && !tx_serial_bit)
      begin
         // Pulse starts on the baud edge that opens the bit
         nxt_state.ir_out = 1'b1;
         if (state_ff.pulse_len == ufc_pkg::PULSE_THREE_SIXTEENTHS)
         begin
            nxt_state.ir_left = ufc_pkg::IR_SHORT_SAMPLES;
            nxt_state.ir_in_samples = 1'b1;
         end
         else
         begin
            nxt_state.ir_left = state_ff.pulse_len;
            nxt_state.ir_in_samples = 1'b0;
         end
      end
      else if (state_ff.ir_left != 8'h00)
      begin
         // Count clocks, or sample ticks in the 3/16 scheme
         if (!state_ff.ir_in_samples || state_ff.btick)
         begin
            nxt_state.ir_left = state_ff.ir_left - 8'h01;
            nxt_state.ir_out = (state_ff.ir_left != 8'h01);
         end
      end
      else
      begin
         nxt_state.ir_out = 1'b0;
      end
   end

   //**********************************************************************
   // State register
   //**********************************************************************
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_ff <= '0;
         state_ff.mode <= ufc_pkg::FRAME_RESET[7:6];
         state_ff.parity <= ufc_pkg::FRAME_RESET[5:4];
         state_ff.stop2 <= ufc_pkg::FRAME_RESET[3];
         state_ff.size_code <= ufc_pkg::FRAME_RESET[2:0];
         state_ff.baud <= ufc_pkg::BAUD_RESET;
         state_ff.presc <= ufc_pkg::BAUD_RESET;
         state_ff.pulse_len <= ufc_pkg::PULSE_RESET;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   //**********************************************************************
   // Outputs
   //**********************************************************************
   // Reserved codes fall to the nearest safe setting: no parity, 8 bits
   assign parity_enable = state_ff.parity[1];
   assign parity_odd = state_ff.parity[1] & state_ff.parity[0];
   assign stop_bit_count = state_ff.stop2;
   assign nine_bit_high_first = (state_ff.size_code == 3'h7);
   always_comb
   begin
      unique case (state_ff.size_code)
         3'h0: char_bits = 4'h5;
         3'h1: char_bits = 4'h6;
         3'h2: char_bits = 4'h7;
         3'h6, 3'h7: char_bits = 4'h9;
         default: char_bits = 4'h8;
      endcase
   end
   // Plain register views
   assign reg_rdata = state_ff.rdata;
   assign multiproc_addressing_enable = state_ff.mp_enable;
   assign comm_mode_select = state_ff.mode;
   assign shift_order = state_ff.order;
   assign sample_phase = state_ff.phase;
   assign baud_tick = state_ff.btick;
   assign bit_tick = state_ff.bitt;
   assign ir_tx_out = state_ff.ir_out;
   assign ir_event_level = state_ff.ev_level;
   assign autobaud_checked = state_ff.ab_checked;
   assign autobaud_in_window = state_ff.ab_ok;
   assign port_halted = halted;

   //**********************************************************************
   // Assertions
   //**********************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   sequence s_ir_start3;
      !ir_tx_out ##1 ir_tx_out && (state_ff.ir_left == 8'h03) && !state_ff.ir_in_samples;
   endsequence
   sequence s_pulse3_body;
      ir_tx_out [*3] ##1 !ir_tx_out;
   endsequence

   a_multiproc_write: assert property (reg_write && reg_addr == 4'h6 |=> multiproc_addressing_enable == $past(reg_wdata[0]))
      else $error("multiprocessor bit not stored");
   a_mode_write: assert property (reg_write && reg_addr == 4'h7 |=> comm_mode_select == $past(reg_wdata[7:6]))
      else $error("mode field not stored");
   a_spi_view: assert property (comm_mode_select == 2'h3 && reg_read && reg_addr == 4'h7 && !reg_write
      |=> reg_rdata[5:3] == 3'h0 && reg_rdata[0] == 1'b0 && reg_rdata[2] == shift_order)
      else $error("spi view shows normal fields");
   a_reset_frame: assert property ($rose(reset_n) |-> comm_mode_select == 2'h0 && char_bits == 4'h8
      && !parity_enable && !stop_bit_count)
      else $error("frame control reset wrong");
   a_parity_map: assert property (parity_odd |-> parity_enable)
      else $error("odd parity without enable");
   a_char_range: assert property (char_bits >= 4'h5 && char_bits <= 4'h9)
      else $error("character size out of range");
   a_spi_fields: assert property (reg_write && reg_addr == 4'h7 && reg_wdata[7:6] == 2'h3
      |=> shift_order == $past(reg_wdata[2]) && sample_phase == $past(reg_wdata[1]))
      else $error("spi order or phase not stored");
   a_baud_reload: assert property (reg_write && reg_addr == 4'h8 |=> state_ff.presc == state_ff.baud)
      else $error("prescaler not reloaded");
   a_bit_tick: assert property (bit_tick |-> baud_tick && $past(state_ff.sample) == 4'hF)
      else $error("bit tick not after sixteen samples");
   a_debug_halt: assert property (halted && !reg_write |=> $stable(state_ff.presc) && !baud_tick)
      else $error("prescaler ran while halted");
   a_window_edge: assert property (sync_count_valid && !halted && constrained_autobaud_mode
      && state_ff.window == 2'h0 && sync_count == 8'd39 |=> !autobaud_in_window && autobaud_checked)
      else $error("count outside window accepted");
   a_ir_pulse3: assert property (s_ir_start3 |-> s_pulse3_body)
      else $error("fixed infrared pulse length wrong");

   // Reload, freeze and pass-through paths; a broken hold shows one edge later
   a_baud_reload_hi: assert property (reg_write && reg_addr == 4'h9 |=> state_ff.presc == state_ff.baud)
      else $error("prescaler not reloaded from high byte");
   a_event_frozen: assert property (state_ff.ev_disable |=> $stable(ir_event_level))
      else $error("event level moved while input disabled");
   a_halt_events: assert property (halted |=> $stable(ir_event_level) && !autobaud_checked)
      else $error("events taken while halted");
   a_normal_restore: assert property (reg_write && reg_addr == 4'h7 && reg_wdata[7:6] != 2'h3 |=> !shift_order)
      else $error("normal layout write kept spi order");
   a_ir_pass: assert property (reset_n && (comm_mode_select != 2'h2 || state_ff.pulse_len == 8'hFF)
      |=> ir_tx_out == $past(tx_serial_bit))
      else $error("infrared output not passing the serial bit");

endmodule // ufc_config

// >>> logic/ufc_pkg.sv
// Constants for the serial port frame, baud and infrared configuration block
//**********************************************************************
//**********************************************************************
package ufc_pkg;
   // Register offsets
   localparam logic [3:0] OFF_CTRL_B = 4'h6;
   localparam logic [3:0] OFF_FRAME = 4'h7;
   localparam logic [3:0] OFF_BAUD_LO = 4'h8;
   localparam logic [3:0] OFF_BAUD_HI = 4'h9;
   localparam logic [3:0] OFF_WINDOW = 4'hA;
   localparam logic [3:0] OFF_DEBUG = 4'hB;
   localparam logic [3:0] OFF_EVENT = 4'hC;
   localparam logic [3:0] OFF_PULSE = 4'hD;
   // Field positions
   localparam int FC_MODE_LSB = 6;
   localparam int FC_PAR_LSB = 4;
   localparam int FC_STOP_BIT = 3;
   localparam int FC_ORDER_BIT = 2;
   localparam int FC_PHASE_BIT = 1;
   localparam int WIN_LSB = 6;
   // Reset values
   localparam logic [7:0] FRAME_RESET = 8'h03;
   localparam logic [15:0] BAUD_RESET = 16'h0000;
   localparam logic [7:0] PULSE_RESET = 8'h00;
   // Codes
   localparam logic [1:0] MODE_SPI = 2'h3;
   localparam logic [1:0] MODE_IR = 2'h2;
   localparam logic [7:0] PULSE_THREE_SIXTEENTHS = 8'h00;
   localparam logic [7:0] PULSE_PASS = 8'hFF;
   // Counts
   localparam logic [3:0] SAMPLES_LAST = 4'hF;
   localparam logic [7:0] IR_SHORT_SAMPLES = 8'h03;
   localparam logic [7:0] PAIR_NOMINAL = 8'h20;
   localparam logic [7:0] TOL_W0 = 8'h06;
   localparam logic [7:0] TOL_W1 = 8'h05;
   localparam logic [7:0] TOL_W2 = 8'h07;
   localparam logic [7:0] TOL_W3 = 8'h08;
endpackage

// >>> test/ufc_ir_peer.sv
// Infrared transceiver at the far side: lights the event input and times pulses
`timescale 1ns/1ns
module ufc_ir_peer
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Optical side
   input wire logic light_req,
   input wire logic ir_tx_out,
   output logic infrared_event_pin,
   output logic [15:0] last_width,
   output logic [15:0] pulse_count
);
   logic [15:0] run;
   // Received light follows the bench; no filter on this side
   assign infrared_event_pin = light_req;
   // Width of each high pulse in clocks, held after it ends
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         run <= 16'h0000;
         last_width <= 16'h0000;
         pulse_count <= 16'h0000;
      end
      else if (ir_tx_out)
         run <= run + 16'h0001;
      else if (run != 16'h0000)
      begin
         last_width <= run;
         pulse_count <= pulse_count + 16'h0001;
         run <= 16'h0000;
      end
   end
endmodule // ufc_ir_peer

// >>> test/test_usart_frame_and_baud_config.sv
// Self-checking bench of the serial port configuration block
`timescale 1ns/1ns
module test_usart_frame_and_baud_config;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic cpu_debug_halted = 1'b0;
   logic constrained_autobaud_mode = 1'b0;
   logic sync_count_valid = 1'b0;
   logic [7:0] sync_count = 8'h00;
   logic tx_serial_bit = 1'b1;
   logic light_req = 1'b0;
   logic [7:0] reg_rdata, v;
   logic [1:0] comm_mode_select;
   logic [3:0] char_bits;
   logic [15:0] last_width, pulse_count;
   logic infrared_event_pin, ir_tx_out, ir_event_level, baud_tick, bit_tick, port_halted;
   logic multiproc_addressing_enable, parity_enable, parity_odd, stop_bit_count, nine_bit_high_first;
   logic shift_order, sample_phase, autobaud_checked, autobaud_in_window, prev;
   logic [31:0] seed = 32'h0000_9B93;
   int miscompares = 0;
   int checks_done = 0;
   int n;
   // Clock of 100 ns period
   always #50 clock = ~clock;
   ufc_config dut
   (
      .clock, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .cpu_debug_halted,
      .constrained_autobaud_mode, .sync_count_valid, .sync_count, .infrared_event_pin, .tx_serial_bit,
      .ir_tx_out, .ir_event_level, .baud_tick, .bit_tick, .multiproc_addressing_enable, .comm_mode_select,
      .parity_enable, .parity_odd, .stop_bit_count, .char_bits, .nine_bit_high_first, .shift_order,
      .sample_phase, .autobaud_checked, .autobaud_in_window, .port_halted
   );
   ufc_ir_peer peer
   (
      .clock, .reset_n, .light_req, .ir_tx_out, .infrared_event_pin, .last_width, .pulse_count
   );
   //***********************
   // Helpers
   //***********************
   function void step();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
   endfunction
   function logic [3:0] exp_bits(input logic [2:0] s);
      return (s < 3'h4) ? {1'b0, s} + 4'h5 : ((s < 3'h6) ? 4'h8 : 4'h9);
   endfunction
   function logic exp_win(input logic [1:0] w, input logic [7:0] c);
      logic [7:0] t;
      t = (w == 2'h0) ? 8'h06 : ((w == 2'h1) ? 8'h05 : ((w == 2'h2) ? 8'h07 : 8'h08));
      return (c >= 8'h20 - t) && (c <= 8'h20 + t);
   endfunction
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task finish_test();
      if (miscompares == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Bus cycles; one idle edge between strobes keeps each driver step single
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      #1;
   endtask
   task rdc(input logic [3:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask
   task ab(input logic [7:0] c, input logic e1, input logic e2);
      @(posedge clock);
      sync_count <= c;
      sync_count_valid <= 1'b1;
      @(posedge clock);
      sync_count_valid <= 1'b0;
      #1;
      chk(autobaud_checked, e1);
      if (e1)
         chk(autobaud_in_window, e2);
   endtask
   task till_tick(output int k);
      k = 0;
      do
      begin
         @(posedge clock);
         #1;
         k++;
      end
      while (!baud_tick && k < 600);
   endtask
   task ev(input logic e);
      int k;
      k = 0;
      while (ir_event_level !== e && k < 8)
      begin
         @(posedge clock);
         #1;
         k++;
      end
      chk(ir_event_level, e);
   endtask
   // Output is the serial bit one clock late
   task pass_check();
      for (int i = 0; i < 16; i++)
      begin
         @(posedge clock);
         prev = tx_serial_bit;
         step();
         tx_serial_bit <= seed[0];
         #1;
         chk(ir_tx_out, prev);
      end
   endtask
   //***********************
   // Scenarios
   //***********************
   initial
   begin
      repeat (4) @(posedge clock);
      reset_n <= 1'b1;
      for (int a = 0; a < 16; a++)
         rdc(a[3:0], (a == 7) ? 8'h03 : 8'h00);
      chk(char_bits, 4'h8);
      chk(comm_mode_select, 2'h0);
      wr(4'hE, 8'hFF);
      rdc(4'hE, 8'h00);
      wr(4'h6, 8'h01);
      chk(multiproc_addressing_enable, 1'b1);
      rdc(4'h6, 8'h01);
      wr(4'h6, 8'h00);
      chk(multiproc_addressing_enable, 1'b0);
      // Every mode, parity and size code outside SPI, random stop bit
      for (int m = 0; m < 3; m++)
         for (int i = 0; i < 32; i++)
         begin
            step();
            v = {m[1:0], i[4:3], seed[0], i[2:0]};
            wr(4'h7, v);
            chk(comm_mode_select, v[7:6]);
            chk(parity_enable, v[5]);
            chk(parity_odd, v[5] & v[4]);
            chk(stop_bit_count, v[3]);
            chk(char_bits, exp_bits(v[2:0]));
            chk(nine_bit_high_first, v[2:0] == 3'h7);
            rdc(4'h7, v);
         end
      // SPI view hides the normal fields but keeps them; a normal layout write clears order
      wr(4'h7, 8'h3B);
      for (int k = 0; k < 4; k++)
      begin
         wr(4'h7, {5'h1F, k[1:0], 1'b1});
         chk(shift_order, k[1]);
         chk(sample_phase, k[0]);
         chk(char_bits, 4'h8);
         rdc(4'h7, {5'h18, k[1:0], 1'b0});
      end
      wr(4'h7, 8'h1A);
      chk(shift_order, 1'b0);
      chk(char_bits, 4'h7);
      rdc(4'h7, 8'h1A);
      // Divisor bytes, period, then a reload in mid-count
      step();
      wr(4'h8, seed[7:0]);
      wr(4'h9, seed[15:8]);
      rdc(4'h8, seed[7:0]);
      rdc(4'h9, seed[15:8]);
      wr(4'h9, 8'h01);
      wr(4'h8, 8'h02);
      till_tick(n);
      till_tick(n);
      chk(n[15:0], 16'h0103);
      repeat (20) @(posedge clock);
      wr(4'h9, 8'h00);
      till_tick(n);
      chk(n <= 4, 1'b1);
      till_tick(n);
      chk(n[15:0], 16'h0003);
      for (int g = 0; g < 200 && !bit_tick; g++)
         @(posedge clock) #1;
      n = 0;
      do
      begin
         @(posedge clock);
         #1;
         n += baud_tick;
      end
      while (!bit_tick && n < 40);
      chk(n[15:0], 16'h0010);
      // Window sizes at every boundary; all counts pass outside that mode
      @(posedge clock);
      constrained_autobaud_mode <= 1'b1;
      for (int w = 0; w < 4; w++)
      begin
         wr(4'hA, {w[1:0], 6'h00});
         rdc(4'hA, {w[1:0], 6'h00});
         for (int c = 23; c < 42; c++)
            ab(c[7:0], 1'b1, exp_win(w[1:0], c[7:0]));
      end
      @(posedge clock);
      constrained_autobaud_mode <= 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         step();
         ab(seed[7:0], 1'b1, 1'b1);
      end
      // Debug halt freezes checks and prescaler unless run is set
      wr(4'hB, 8'h00);
      @(posedge clock);
      cpu_debug_halted <= 1'b1;
      #1;
      chk(port_halted, 1'b1);
      ab(8'h20, 1'b0, 1'b0);
      repeat (2) @(posedge clock);
      n = 0;
      repeat (12)
      begin
         @(posedge clock);
         #1;
         n += baud_tick;
      end
      chk(n[15:0], 16'h0000);
      wr(4'hB, 8'h01);
      chk(port_halted, 1'b0);
      rdc(4'hB, 8'h01);
      ab(8'h20, 1'b1, 1'b1);
      @(posedge clock);
      cpu_debug_halted <= 1'b0;
      // Event input enabled by a zero, frozen by a one
      wr(4'hC, 8'h00);
      @(posedge clock);
      light_req <= 1'b1;
      ev(1'b1);
      wr(4'hC, 8'h01);
      rdc(4'hC, 8'h01);
      @(posedge clock);
      light_req <= 1'b0;
      repeat (10) @(posedge clock);
      ev(1'b1);
      wr(4'hC, 8'h00);
      ev(1'b0);
      // Pulse length goes in before the mode turns infrared
      wr(4'h8, 8'h01);
      wr(4'hD, 8'h03);
      rdc(4'hD, 8'h03);
      wr(4'h7, 8'h83);
      @(posedge clock);
      tx_serial_bit <= 1'b0;
      for (int k = 0; k < 3; k++)
      begin
         v = (k == 0) ? 8'h01 : ((k == 1) ? 8'h03 : 8'h00);
         wr(4'hD, v);
         repeat (80) @(posedge clock);
         #1;
         chk(last_width, (k == 2) ? 16'h0006 : {8'h00, v});
      end
      wr(4'hD, 8'hFF);
      pass_check();
      // Idle line so no pulse is cut by the mode change
      @(posedge clock);
      tx_serial_bit <= 1'b1;
      wr(4'hD, 8'h03);
      wr(4'h7, 8'h03);
      pass_check();
      // Reset in mid-run brings back every reset value
      wr(4'h7, 8'h7C);
      @(posedge clock);
      reset_n <= 1'b0;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      rdc(4'h7, 8'h03);
      rdc(4'h8, 8'h00);
      rdc(4'hD, 8'h00);
      finish_test();
   end
   // Watchdog well beyond the fewer than two thousand cycles of the run
   initial
   begin
      #2000000;
      miscompares++;
      finish_test();
   end
endmodule // test_usart_frame_and_baud_config
